// >>> shared/rtc_cal_pkg.sv
// How it works
// - Years hold two BCD digits, tens high nibble, units low, 00 to 99.
// - Month is BCD with tens in bit 4; bits 7..5 read zero.
// - Date is BCD, units 0-9, tens 0-3, valid range 1 to 31.
// - Date counter handles leap-year February without any host action.
// - Weekday in bits 2..0 rings 1 to 7 then 1, independent of date.
// - Hours are 24-hour BCD, two-bit tens digit, valid range 0 to 23.
// - Tens-of-hours digit counts only 0 to 2, then returns to 0.
// - Hours bit 7 is a stored format flag that does not change the count; bit 6 reads zero.
// - Minutes BCD, upper digit in bits 6..4, bit 7 reads zero.
package rtc_cal_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [16:0] MINUTES_OFS = 17'h1_FFFA;
  localparam logic [16:0] HOURS_OFS = 17'h1_FFFB;
  localparam logic [16:0] WEEKDAY_OFS = 17'h1_FFFC;
  localparam logic [16:0] DATE_OFS = 17'h1_FFFD;
  localparam logic [16:0] MONTH_OFS = 17'h1_FFFE;
  localparam logic [16:0] YEAR_OFS = 17'h1_FFFF;

  // ****************************************
  // Field layout
  // ****************************************
  localparam logic [7:0] MINUTES_MASK = 8'h7F;
  localparam logic [7:0] HOURS_MASK = 8'h3F;
  localparam logic [7:0] WEEKDAY_MASK = 8'h07;
  localparam logic [7:0] DATE_MASK = 8'h3F;
  localparam logic [7:0] MONTH_MASK = 8'h1F;
  localparam logic [7:0] YEAR_MASK = 8'hFF;
  localparam int HOUR_FMT_BIT = 7;

  // ****************************************
  // Counting limits in BCD
  // ****************************************
  localparam logic [7:0] MINUTES_LAST = 8'h59;
  localparam logic [7:0] HOURS_LAST = 8'h23;
  localparam logic [7:0] MONTH_LAST = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] ZERO_FIRST = 8'h00;
  localparam logic [7:0] ONE_FIRST = 8'h01;
  localparam logic [2:0] WEEKDAY_LAST = 3'h7;
  localparam logic [2:0] WEEKDAY_FIRST = 3'h1;
  localparam logic [7:0] FEB_BCD = 8'h02;
  localparam logic [7:0] APR_BCD = 8'h04;
  localparam logic [7:0] JUN_BCD = 8'h06;
  localparam logic [7:0] SEP_BCD = 8'h09;
  localparam logic [7:0] NOV_BCD = 8'h11;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] MINUTES_RST = 8'h00;
  localparam logic [7:0] HOURS_RST = 8'h00;
  localparam logic [2:0] WEEKDAY_RST = 3'h1;
  localparam logic [7:0] DATE_RST = 8'h01;
  localparam logic [7:0] MONTH_RST = 8'h01;
  localparam logic [7:0] YEAR_RST = 8'h00;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [16:0] addr;
    logic [7:0] data;
    logic chip_en_n;
    logic write_en_n;
    logic out_en_n;
  } host_bus_t;

  typedef struct packed {
    logic [7:0] data;
    logic oe_n;
  } dq_drive_t;

endpackage

// >>> hdl/bcd_step.sv
`timescale 1ns/1ps
module bcd_step
  import rtc_cal_pkg::*;
(
  // Counter value and limits
  input wire logic [7:0] value_in,
  input wire logic [7:0] last_in,
  input wire logic [7:0] first_in,
  // Advance request
  input wire logic step_in,
  // Result
  output logic [7:0] result_out,
  output logic carry_out
);

  // A value already past the limit also wraps, so a bad host write heals.
  always_comb begin
    result_out = value_in;
    carry_out = 1'b0;
    if (step_in) begin
      if (value_in >= last_in) begin
        result_out = first_in;
        carry_out = 1'b1;
      end else if (value_in[3:0] >= 4'h9) begin
        result_out = {value_in[7:4] + 4'h1, 4'h0};
      end else begin
        result_out = {value_in[7:4], value_in[3:0] + 4'h1};
      end
    end
  end

endmodule // bcd_step

// >>> hdl/rtc_calendar.sv
`timescale 1ns/1ps
module rtc_calendar
  import rtc_cal_pkg::*;
(
  // Clock, reset and enable
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  // Time base, one pulse per minute
  input wire logic MINUTE_TICK_IN,
  // Host memory bus
  input wire host_bus_t BUS_IN,
  // Data pins
  output dq_drive_t DQ_OUT
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] minutes;
    logic [7:0] hours;
    logic hour_fmt;
    logic [2:0] weekday;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic wr_active;
    logic [16:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic rd_drive;
  } state_t;

  state_t q;
  state_t next_q;

  // ****************************************
  // Helpers
  // ****************************************
  // A BCD year is a multiple of four when an even tens digit meets
  // 0, 4 or 8, or an odd tens digit meets 2 or 6.
  function automatic logic is_leap(input logic [7:0] yr);
    logic odd_tens;
    odd_tens = yr[4];
    if (odd_tens) begin
      is_leap = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
    end else begin
      is_leap = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) ||
                (yr[3:0] == 4'h8);
    end
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] mon,
                                            input logic [7:0] yr);
    case (mon)
      FEB_BCD: month_days = is_leap(yr) ? DAYS_29 : DAYS_28;
      APR_BCD, JUN_BCD, SEP_BCD, NOV_BCD: month_days = DAYS_30;
      default: month_days = DAYS_31;
    endcase
  endfunction

  function automatic logic in_map(input logic [16:0] a);
    in_map = (a >= MINUTES_OFS) && (a <= YEAR_OFS);
  endfunction

  // ****************************************
  // Counter chain
  // ****************************************
  logic [7:0] min_next;
  logic [7:0] hour_next;
  logic [7:0] date_next;
  logic [7:0] month_next;
  logic [7:0] year_next;
  logic min_carry;
  logic hour_carry;
  logic date_carry;
  logic month_carry;
  logic [7:0] date_last;

  assign date_last = month_days(q.month, q.year);

  bcd_step u_min (
    .value_in(q.minutes),
    .last_in(MINUTES_LAST),
    .first_in(ZERO_FIRST),
    .step_in(MINUTE_TICK_IN),
    .result_out(min_next),
    .carry_out(min_carry)
  );

  // The hour limit of 23 keeps the tens digit within 0 to 2.
  bcd_step u_hour (
    .value_in(q.hours),
    .last_in(HOURS_LAST),
    .first_in(ZERO_FIRST),
    .step_in(min_carry),
    .result_out(hour_next),
    .carry_out(hour_carry)
  );

  bcd_step u_date (
    .value_in(q.date),
    .last_in(date_last),
    .first_in(ONE_FIRST),
    .step_in(hour_carry),
    .result_out(date_next),
    .carry_out(date_carry)
  );

  bcd_step u_month (
    .value_in(q.month),
    .last_in(MONTH_LAST),
    .first_in(ONE_FIRST),
    .step_in(date_carry),
    .result_out(month_next),
    .carry_out(month_carry)
  );

  bcd_step u_year (
    .value_in(q.year),
    .last_in(YEAR_LAST),
    .first_in(ZERO_FIRST),
    .step_in(month_carry),
    .result_out(year_next),
    .carry_out()
  );

  // ****************************************
  // Bus decode
  // ****************************************
  logic sel;
  logic write_now;
  logic commit;

  assign sel = !BUS_IN.chip_en_n && in_map(BUS_IN.addr);
  assign write_now = sel && !BUS_IN.write_en_n;
  // A write lands when the strobe ends, so late data setup is honoured.
  assign commit = q.wr_active && !write_now;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_q = q;
    next_q.minutes = min_next & MINUTES_MASK;
    next_q.hours = hour_next & HOURS_MASK;
    next_q.date = date_next & DATE_MASK;
    next_q.month = month_next & MONTH_MASK;
    next_q.year = year_next & YEAR_MASK;
    if (hour_carry) begin
      if (q.weekday >= WEEKDAY_LAST || q.weekday == 3'h0) begin
        next_q.weekday = WEEKDAY_FIRST;
      end else begin
        next_q.weekday = q.weekday + 3'h1;
      end
    end

    // Host writes win over a count in the same cycle.
    next_q.wr_active = write_now;
    if (write_now) begin
      next_q.wr_addr = BUS_IN.addr;
      next_q.wr_data = BUS_IN.data;
    end
    if (commit) begin
      case (q.wr_addr)
        MINUTES_OFS: next_q.minutes = q.wr_data & MINUTES_MASK;
        HOURS_OFS: begin
          next_q.hours = q.wr_data & HOURS_MASK;
          next_q.hour_fmt = q.wr_data[HOUR_FMT_BIT];
        end
        WEEKDAY_OFS: next_q.weekday = q.wr_data[2:0];
        DATE_OFS: next_q.date = q.wr_data & DATE_MASK;
        MONTH_OFS: next_q.month = q.wr_data & MONTH_MASK;
        YEAR_OFS: next_q.year = q.wr_data & YEAR_MASK;
        default: next_q.wr_data = q.wr_data;
      endcase
    end

    // Read data is registered; it follows the address one cycle late.
    next_q.rd_drive = sel && BUS_IN.write_en_n && !BUS_IN.out_en_n;
    case (BUS_IN.addr)
      MINUTES_OFS: next_q.rd_data = q.minutes & MINUTES_MASK;
      HOURS_OFS: begin
        next_q.rd_data = q.hours & HOURS_MASK;
        next_q.rd_data[HOUR_FMT_BIT] = q.hour_fmt;
      end
      WEEKDAY_OFS: next_q.rd_data = {5'h00, q.weekday};
      DATE_OFS: next_q.rd_data = q.date & DATE_MASK;
      MONTH_OFS: next_q.rd_data = q.month & MONTH_MASK;
      YEAR_OFS: next_q.rd_data = q.year & YEAR_MASK;
      default: next_q.rd_data = 8'h00;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      q.minutes <= MINUTES_RST;
      q.hours <= HOURS_RST;
      q.hour_fmt <= 1'b0;
      q.weekday <= WEEKDAY_RST;
      q.date <= DATE_RST;
      q.month <= MONTH_RST;
      q.year <= YEAR_RST;
      q.wr_active <= 1'b0;
      q.wr_addr <= 17'h0_0000;
      q.wr_data <= 8'h00;
      q.rd_data <= 8'h00;
      q.rd_drive <= 1'b0;
    end else if (CE_IN) begin
      q <= next_q;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // One driver for the whole carrier keeps the port a single-source variable.
  assign DQ_OUT = '{data: q.rd_data, oe_n: !q.rd_drive};

endmodule // rtc_calendar

// >>> verification/rtc_calendar_checker.sv
`timescale 1ns/1ps
module rtc_calendar_checker
  import rtc_cal_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic MINUTE_TICK_IN,
  input wire host_bus_t BUS_IN,
  input wire dq_drive_t DQ_OUT
);
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RST_IN);
  logic rd;
  assign rd = CE_IN && !RST_IN && !BUS_IN.chip_en_n && BUS_IN.write_en_n &&
    !BUS_IN.out_en_n;
  sequence s_rd(logic [16:0] ofs);
    rd && BUS_IN.addr == ofs;
  endsequence
  property p_mask(logic [16:0] ofs, logic [7:0] keep);
    s_rd(ofs) |=> (DQ_OUT.data & ~keep) == 8'h00;
  endproperty
  a_reset_idle: assert property ($fell(RST_IN) && $past(CE_IN) |->
    DQ_OUT.oe_n && DQ_OUT.data == 8'h00) else $error("not idle after reset");
  a_read_drive: assert property (rd && BUS_IN.addr >= MINUTES_OFS |=>
    !DQ_OUT.oe_n) else $error("read not answered");
  a_unmapped_quiet: assert property (CE_IN && BUS_IN.addr < MINUTES_OFS |=>
    DQ_OUT.oe_n) else $error("unmapped address driven");
  a_minutes_mask: assert property (p_mask(MINUTES_OFS, 8'h7F))
    else $error("minutes spare bit set");
  a_hours_mask: assert property (p_mask(HOURS_OFS, 8'hBF))
    else $error("hours bit 6 set");
  a_weekday_mask: assert property (p_mask(WEEKDAY_OFS, 8'h07))
    else $error("weekday spare bits set");
  a_date_mask: assert property (p_mask(DATE_OFS, 8'h3F))
    else $error("date spare bits set");
  a_month_mask: assert property (p_mask(MONTH_OFS, 8'h1F))
    else $error("month spare bits set");
  a_hours_tens: assert property (s_rd(HOURS_OFS) |=>
    DQ_OUT.data[5:4] != 2'b11) else $error("hour tens above 2");
  a_year_digits: assert property (s_rd(YEAR_OFS) |=>
    DQ_OUT.data[7:4] <= 4'h9 && DQ_OUT.data[3:0] <= 4'h9)
    else $error("year digit above 9");
endmodule // rtc_calendar_checker
bind rtc_calendar rtc_calendar_checker u_chk (.CLOCK_IN(CLOCK_IN),
  .RST_IN(RST_IN), .CE_IN(CE_IN), .MINUTE_TICK_IN(MINUTE_TICK_IN),
  .BUS_IN(BUS_IN), .DQ_OUT(DQ_OUT));

// >>> verification/host_model.sv
`timescale 1ns/1ps
module host_model
  import rtc_cal_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire dq_drive_t DQ_OUT,
  output host_bus_t BUS_OUT
);
  initial BUS_OUT = '{17'h0_0000, 8'h00, 1'b1, 1'b1, 1'b1};
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    @(posedge CLOCK_IN);
    BUS_OUT <= '{a, d, 1'b0, 1'b0, 1'b1};
    @(posedge CLOCK_IN);
    BUS_OUT.chip_en_n <= 1'b1;
    BUS_OUT.write_en_n <= 1'b1;
    // A released data bus must not keep showing the written byte.
    BUS_OUT.data <= ~d;
  endtask
  task automatic rd(input logic [16:0] a, output logic [7:0] d,
      output logic oe);
    @(posedge CLOCK_IN);
    BUS_OUT <= '{a, ~BUS_OUT.data, 1'b0, 1'b1, 1'b0};
    repeat (2) @(posedge CLOCK_IN);
    d = DQ_OUT.data;
    oe = DQ_OUT.oe_n;
    BUS_OUT.chip_en_n <= 1'b1;
    BUS_OUT.out_en_n <= 1'b1;
  endtask
endmodule // host_model

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import rtc_cal_pkg::*;
;
  logic clock, rst = 1'b1, ce = 1'b1, tick = 1'b0, fmt, oe;
  logic [7:0] d;
  host_bus_t bus;
  dq_drive_t dq;
  int compares = 0, miscompares = 0, cycles = 0;
  int mi, hr, wd, dt, mo, yr;
  integer seed = 32'h2cdb;
  int cases[5][3] = '{'{28, 2, 4}, '{28, 2, 3}, '{29, 2, 8}, '{30, 4, 5},
    '{31, 12, 99}};
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  miscompares++; $display("ERROR %s expected %h seen %h", n, e, g); end end
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  rtc_calendar DUT (.CLOCK_IN(clock), .RST_IN(rst), .CE_IN(ce),
    .MINUTE_TICK_IN(tick), .BUS_IN(bus), .DQ_OUT(dq));
  host_model host (.CLOCK_IN(clock), .DQ_OUT(dq), .BUS_OUT(bus));
  function automatic logic [7:0] bcd(int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction
  function automatic int mlen(int m, int y);
    if (m == 2) return (y % 4 == 0) ? 29 : 28;
    return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
  endfunction
  task automatic pulse();
    @(posedge clock);
    tick <= 1'b1;
    @(posedge clock);
    tick <= 1'b0;
    if (ce) begin
      mi = (mi + 1) % 60;
      if (mi == 0) hr = (hr + 1) % 24;
      if (mi == 0 && hr == 0) begin
        wd = wd % 7 + 1;
        dt = dt % mlen(mo, yr) + 1;
        if (dt == 1) mo = mo % 12 + 1;
        if (dt == 1 && mo == 1) yr = (yr + 1) % 100;
      end
    end
  endtask
  task automatic put(int m, int h, int w, int t, int n, int y);
    mi = m;
    hr = h;
    wd = w;
    dt = t;
    mo = n;
    yr = y;
    host.wr(MINUTES_OFS, bcd(m));
    host.wr(HOURS_OFS, bcd(h) | {fmt, 7'h00});
    host.wr(WEEKDAY_OFS, bcd(w));
    host.wr(DATE_OFS, bcd(t));
    host.wr(MONTH_OFS, bcd(n));
    host.wr(YEAR_OFS, bcd(y));
  endtask
  task automatic check_all();
    host.rd(MINUTES_OFS, d, oe);
    `CHK("minutes", bcd(mi), d)
    `CHK("minutes drive", 1'b0, oe)
    host.rd(HOURS_OFS, d, oe);
    `CHK("hours", bcd(hr) | {fmt, 7'h00}, d)
    `CHK("hours drive", 1'b0, oe)
    host.rd(WEEKDAY_OFS, d, oe);
    `CHK("weekday", bcd(wd), d)
    `CHK("weekday drive", 1'b0, oe)
    host.rd(DATE_OFS, d, oe);
    `CHK("date", bcd(dt), d)
    `CHK("date drive", 1'b0, oe)
    host.rd(MONTH_OFS, d, oe);
    `CHK("month", bcd(mo), d)
    `CHK("month drive", 1'b0, oe)
    host.rd(YEAR_OFS, d, oe);
    `CHK("year", bcd(yr), d)
    `CHK("year drive", 1'b0, oe)
  endtask
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    {mi, hr, wd, dt, mo, yr, fmt} = {32'd0, 32'd0, 32'd1, 32'd1, 32'd1,
      32'd0, 1'b0};
    check_all();
    $display("test reset done");
    // Last minute of a day so the carry reaches the date in every case, and the year only at 31 Dec 99.
    foreach (cases[i]) begin
      fmt = i[0];
      put(59, 23, 7, cases[i][0], cases[i][1], cases[i][2]);
      pulse();
      check_all();
    end
    $display("test carry done");
    repeat (8) begin
      put($unsigned($random(seed)) % 60, $unsigned($random(seed)) % 24,
        $unsigned($random(seed)) % 7 + 1, $unsigned($random(seed)) % 28 + 1,
        $unsigned($random(seed)) % 12 + 1, $unsigned($random(seed)) % 100);
      pulse();
      check_all();
    end
    $display("test random done");
    ce <= 1'b0;
    pulse();
    ce <= 1'b1;
    host.wr(17'h1_FFF9, 8'h55);
    host.rd(17'h1_FFF9, d, oe);
    `CHK("unmapped drive", 1'b1, oe)
    check_all();
    $display("test freeze done");
    // A second reset in mid-run must bring every counter back home.
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    {mi, hr, wd, dt, mo, yr, fmt} = {32'd0, 32'd0, 32'd1, 32'd1, 32'd1,
      32'd0, 1'b0};
    check_all();
    $display("test mid reset done");
    summarize();
  end
endmodule // tb_top
